// file: shared/uart_status_consts.svh
// Notes on behaviour
// - loopback bit feeds transmit line to receiver
// - overrun set on unread buffer, read clears
// - parity error flag; reads zero when disabled
// - summary flag is OR of four errors
// - address mode: bit 1 marks address character
// - idle mode: bit 1 marks preceding idle line
// - busy bit high while sending or receiving
// - receive buffer read clears receive flags
// - seven-bit receive data, top bit zero
// - writable transmit buffer feeds shift register
// - transmit buffer write clears transmit flag
// - seven-bit mode: top transmit bit unused, zero
`ifndef UART_STATUS_CONSTS_SVH
`define UART_STATUS_CONSTS_SVH
// ****************************************
// register map
// ****************************************
`define OFF_STATUS    8'h00
`define OFF_RXBUF     8'h04
`define OFF_TXBUF     8'h08
`define OFF_CTRL      8'h0C
`define OFF_IRQ_STAT  8'h10
`define OFF_IRQ_MASK  8'h14
`define ST_LOOP       7
`define CTRL_SWRST    0
`define CTRL_PEN      1
`define CTRL_PEVEN    2
`define CTRL_SEVEN    3
`define CTRL_MODE     4
`define CTRL_TXADDR   6
`define CTRL_RST      8'h01
`define IRQ_RX        0
`define IRQ_TX        1
`define IRQ_ERR       2
`define IRQ_STAT_RST  8'h02
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
// ****************************************
// timing
// ****************************************
`define CLK_HZ        40000000
`define BAUD_HZ       115200
`define BIT_CYCLES    (`CLK_HZ / `BAUD_HZ)
`define IDLE_BITS     10
`define IDLE_CYCLES   (`BIT_CYCLES * `IDLE_BITS)
`endif

// file: shared/uart_status_pkg.sv
package uart_status_pkg;
  typedef enum logic [1:0] {MP_NONE, MP_IDLE, MP_ADDR, MP_RSVD} mp_mode_type;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_type;
endpackage : uart_status_pkg

// file: shared/serial_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface serial_core_if;
  logic                         seven;
  logic                         pen;
  logic                         peven;
  uart_status_pkg::mp_mode_type mode;
  logic                         tx_addr;
  logic                         tx_start;
  logic [7:0]                   tx_data;
  logic                         tx_busy;
  logic                         tx_line;
  logic                         rx_line;
  logic                         rx_valid;
  logic [7:0]                   rx_data;
  logic                         rx_fe;
  logic                         rx_pe;
  logic                         rx_brk;
  logic                         rx_addr;
  logic                         rx_idle;
  logic                         rx_busy;
  modport top_mp (output seven, pen, peven, mode, tx_addr, tx_start, tx_data, rx_line,
                  input tx_busy, tx_line, rx_valid, rx_data, rx_fe, rx_pe, rx_brk,
                  rx_addr, rx_idle, rx_busy);
  modport tx_mp (input seven, pen, peven, mode, tx_addr, tx_start, tx_data,
                 output tx_busy, tx_line);
  modport rx_mp (input seven, pen, peven, mode, rx_line,
                 output rx_valid, rx_data, rx_fe, rx_pe, rx_brk, rx_addr, rx_idle, rx_busy);
endinterface : serial_core_if
`default_nettype wire

// file: rtl/uart_tx_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_consts.svh"
module uart_tx_shift (
  input  wire logic     clk_i,
  input  wire logic     rst_b_i,
  serial_core_if.tx_mp  ifc
);
  uart_status_pkg::tx_state_type state_r;
  logic [8:0]  cnt_r;
  logic [11:0] frame_r;
  logic [3:0]  len_r;
  logic [11:0] frame_nxt;
  logic [3:0]  len_nxt;
  logic        line_r;
  logic        par;
  // ****************************************
  // frame build: start, data, addr, parity, stop
  // ****************************************
  always_comb begin
    frame_nxt = 12'h0FFF;
    frame_nxt[0] = 1'b0;
    len_nxt = ifc.seven ? 4'd8 : 4'd9;
    frame_nxt[8:1] = ifc.tx_data;
    if (ifc.seven) begin
      frame_nxt[8] = 1'b1; // msb never sent
    end
    par = ^(ifc.tx_data & (ifc.seven ? 8'h7F : 8'hFF));
    if (ifc.mode == uart_status_pkg::MP_ADDR) begin
      frame_nxt[len_nxt] = ifc.tx_addr;
      par = par ^ ifc.tx_addr;
      len_nxt = len_nxt + 4'd1;
    end
    if (ifc.pen) begin
      frame_nxt[len_nxt] = ifc.peven ? par : ~par;
      len_nxt = len_nxt + 4'd1;
    end
    frame_nxt[len_nxt] = 1'b1;
    len_nxt = len_nxt + 4'd1;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= uart_status_pkg::TX_IDLE;
      cnt_r   <= 9'h000;
      frame_r <= 12'h0FFF;
      len_r   <= 4'h0;
      line_r  <= 1'b1;
    end else begin
      case (state_r)
        uart_status_pkg::TX_IDLE: begin
          line_r <= 1'b1;
          if (ifc.tx_start) begin
            frame_r <= frame_nxt;
            len_r   <= len_nxt;
            cnt_r   <= 9'(`BIT_CYCLES - 1);
            line_r  <= 1'b0;
            state_r <= uart_status_pkg::TX_SHIFT;
          end
        end
        uart_status_pkg::TX_SHIFT: begin
          if (cnt_r != 9'h000) begin
            cnt_r <= cnt_r - 9'h001;
          end else if (len_r == 4'h1) begin
            line_r  <= 1'b1;
            state_r <= uart_status_pkg::TX_IDLE;
          end else begin
            frame_r <= {1'b1, frame_r[11:1]};
            line_r  <= frame_r[1];
            len_r   <= len_r - 4'h1;
            cnt_r   <= 9'(`BIT_CYCLES - 1);
          end
        end
        default: state_r <= uart_status_pkg::TX_IDLE;
      endcase
    end
  end
  assign ifc.tx_line = line_r;
  assign ifc.tx_busy = (state_r != uart_status_pkg::TX_IDLE);
endmodule : uart_tx_shift
`default_nettype wire

// file: rtl/uart_rx_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_consts.svh"
module uart_rx_shift (
  input  wire logic     clk_i,
  input  wire logic     rst_b_i,
  serial_core_if.rx_mp  ifc
);
  uart_status_pkg::rx_state_type state_r;
  logic [8:0]  cnt_r;
  logic [11:0] idle_cnt_r;
  logic        idle_seen_r;
  logic [9:0]  sh_r;
  logic [3:0]  idx_r;
  logic [3:0]  dlen;
  logic [3:0]  len;
  logic        amode;
  logic [9:0]  mask;
  logic        exp_par;
  logic        valid_r;
  logic [7:0]  data_r;
  logic        fe_r;
  logic        pe_r;
  logic        brk_r;
  logic        addr_r;
  logic        idle_r;
  always_comb begin
    amode   = (ifc.mode == uart_status_pkg::MP_ADDR);
    dlen    = ifc.seven ? 4'd7 : 4'd8;
    len     = dlen + {3'h0, amode} + {3'h0, ifc.pen};
    mask    = 10'((11'h001 << len) - 11'h001);
    exp_par = ^(sh_r[7:0] & (ifc.seven ? 8'h7F : 8'hFF)) ^ (amode & sh_r[dlen]);
    exp_par = ifc.peven ? exp_par : ~exp_par;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r     <= uart_status_pkg::RX_IDLE;
      cnt_r       <= 9'h000;
      idle_cnt_r  <= 12'h000;
      idle_seen_r <= 1'b0;
      sh_r        <= 10'h000;
      idx_r       <= 4'h0;
      valid_r     <= 1'b0;
      data_r      <= 8'h00;
      fe_r        <= 1'b0;
      pe_r        <= 1'b0;
      brk_r       <= 1'b0;
      addr_r      <= 1'b0;
      idle_r      <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      case (state_r)
        uart_status_pkg::RX_IDLE: begin
          // line high long enough counts as idle
          if (ifc.rx_line && idle_cnt_r != 12'(`IDLE_CYCLES)) begin
            idle_cnt_r <= idle_cnt_r + 12'h001;
          end
          if (!ifc.rx_line) begin
            idle_seen_r <= (idle_cnt_r == 12'(`IDLE_CYCLES));
            idle_cnt_r  <= 12'h000;
            cnt_r       <= 9'(`BIT_CYCLES / 2);
            state_r     <= uart_status_pkg::RX_START;
          end
        end
        uart_status_pkg::RX_START: begin
          if (cnt_r != 9'h000) begin
            cnt_r <= cnt_r - 9'h001;
          end else begin
            // glitch on start bit drops back to idle
            state_r <= ifc.rx_line ? uart_status_pkg::RX_IDLE : uart_status_pkg::RX_BITS;
            cnt_r   <= 9'(`BIT_CYCLES - 1);
            idx_r   <= 4'h0;
            sh_r    <= 10'h000;
          end
        end
        uart_status_pkg::RX_BITS: begin
          if (cnt_r != 9'h000) begin
            cnt_r <= cnt_r - 9'h001;
          end else begin
            sh_r[idx_r] <= ifc.rx_line;
            idx_r       <= idx_r + 4'h1;
            cnt_r       <= 9'(`BIT_CYCLES - 1);
            if (idx_r == len - 4'h1) begin
              state_r <= uart_status_pkg::RX_STOP;
            end
          end
        end
        uart_status_pkg::RX_STOP: begin
          if (cnt_r != 9'h000) begin
            cnt_r <= cnt_r - 9'h001;
          end else begin
            valid_r <= 1'b1;
            data_r  <= sh_r[7:0] & (ifc.seven ? 8'h7F : 8'hFF);
            fe_r    <= !ifc.rx_line;
            pe_r    <= ifc.pen && (sh_r[len - 4'h1] != exp_par);
            brk_r   <= ((sh_r & mask) == 10'h000) && !ifc.rx_line;
            addr_r  <= amode && sh_r[dlen];
            idle_r  <= idle_seen_r;
            state_r <= uart_status_pkg::RX_IDLE;
          end
        end
        default: state_r <= uart_status_pkg::RX_IDLE;
      endcase
    end
  end
  assign ifc.rx_valid = valid_r;
  assign ifc.rx_data  = data_r;
  assign ifc.rx_fe    = fe_r;
  assign ifc.rx_pe    = pe_r;
  assign ifc.rx_brk   = brk_r;
  assign ifc.rx_addr  = addr_r;
  assign ifc.rx_idle  = idle_r;
  assign ifc.rx_busy  = (state_r != uart_status_pkg::RX_IDLE);
endmodule : uart_rx_shift
`default_nettype wire

// file: rtl/uart_status_buffers.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_consts.svh"
module uart_status_buffers (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] s_axi_awaddr_i,
  input  wire logic       s_axi_awvalid_i,
  output logic            s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0] s_axi_wstrb_i,
  input  wire logic       s_axi_wvalid_i,
  output logic            s_axi_wready_o,
  output logic [1:0]      s_axi_bresp_o,
  output logic            s_axi_bvalid_o,
  input  wire logic       s_axi_bready_i,
  input  wire logic [7:0] s_axi_araddr_i,
  input  wire logic       s_axi_arvalid_i,
  output logic            s_axi_arready_o,
  output logic [31:0]     s_axi_rdata_o,
  output logic [1:0]      s_axi_rresp_o,
  output logic            s_axi_rvalid_o,
  input  wire logic       s_axi_rready_i,
  input  wire logic       serial_rx_line_i,
  output logic            serial_tx_line_o,
  output logic            irq_o
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
    is_reg = (addr[7:2] == off[7:2]);
  endfunction : is_reg

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = is_reg(addr, `OFF_STATUS) || is_reg(addr, `OFF_RXBUF) ||
                is_reg(addr, `OFF_TXBUF) || is_reg(addr, `OFF_CTRL) ||
                is_reg(addr, `OFF_IRQ_STAT) || is_reg(addr, `OFF_IRQ_MASK);
  endfunction : is_mapped

  serial_core_if ifc ();

  logic       core_rst_b;
  logic [7:0] ctrl_r;
  logic       loop_r;
  logic [7:0] irq_mask_r;
  logic [7:0] irq_stat_r;
  logic [7:0] txbuf_r;
  logic       tx_full_r;
  logic [7:0] rxbuf_r;
  logic       rx_full_r;
  logic       fe_r;
  logic       oe_r;
  logic       pe_r;
  logic       brk_r;
  logic       ai_r;
  logic       pe_vis;
  logic       err_sum;
  logic       busy;
  logic [7:0] status_val;
  logic       aw_hold_r;
  logic [7:0] aw_addr_r;
  logic       w_hold_r;
  logic [7:0] w_data_r;
  logic       w_strb0_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic       do_write;
  logic       wr_en;
  logic       ar_hs;
  logic       rd_rx;
  logic       wr_tx;
  logic       tx_load;
  logic       rx_err;
  logic [7:0] irq_set;
  logic [7:0] irq_w1c;

  // ****************************************
  // serial engines
  // ****************************************
  // software reset bit holds both shifters idle
  assign core_rst_b = rst_b_i && !ctrl_r[`CTRL_SWRST];

  assign ifc.seven    = ctrl_r[`CTRL_SEVEN];
  assign ifc.pen      = ctrl_r[`CTRL_PEN];
  assign ifc.peven    = ctrl_r[`CTRL_PEVEN];
  assign ifc.mode     = uart_status_pkg::mp_mode_type'(ctrl_r[`CTRL_MODE +: 2]);
  assign ifc.tx_addr  = ctrl_r[`CTRL_TXADDR];
  assign ifc.tx_data  = txbuf_r;
  assign ifc.rx_line  = loop_r ? ifc.tx_line : serial_rx_line_i;
  // buffer moves to the shifter as soon as it is free
  assign tx_load      = tx_full_r && !ifc.tx_busy && core_rst_b;
  assign ifc.tx_start = tx_load;

  uart_tx_shift u_tx (
    .clk_i   (core_clk_i),
    .rst_b_i (core_rst_b),
    .ifc     (ifc.tx_mp)
  );

  uart_rx_shift u_rx (
    .clk_i   (core_clk_i),
    .rst_b_i (core_rst_b),
    .ifc     (ifc.rx_mp)
  );

  assign serial_tx_line_o = ifc.tx_line;

  // ****************************************
  // status view
  // ****************************************
  assign pe_vis  = pe_r && ctrl_r[`CTRL_PEN];
  assign err_sum = fe_r || oe_r || pe_vis || brk_r;
  assign busy    = ifc.tx_busy || ifc.rx_busy;
  assign status_val = {loop_r, fe_r, oe_r, pe_vis, brk_r, err_sum, ai_r, busy};

  // ****************************************
  // bus slave
  // ****************************************
  assign s_axi_awready_o = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_o  = !w_hold_r && !bvalid_r;
  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;

  assign do_write = aw_hold_r && w_hold_r;
  assign wr_en    = do_write && w_strb0_r;
  assign ar_hs    = s_axi_arvalid_i && !rvalid_r;
  assign rd_rx    = ar_hs && is_reg(s_axi_araddr_i, `OFF_RXBUF);
  assign wr_tx    = wr_en && is_reg(aw_addr_r, `OFF_TXBUF);

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      w_hold_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_strb0_r <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold_r  <= 1'b1;
      w_data_r  <= s_axi_wdata_i[7:0];
      w_strb0_r <= s_axi_wstrb_i[0];
    end else if (do_write) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rresp_r  <= is_mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_r  <= 32'h0000_0000;
      if (is_reg(s_axi_araddr_i, `OFF_STATUS)) begin
        rdata_r[7:0] <= status_val;
      end
      if (is_reg(s_axi_araddr_i, `OFF_RXBUF)) begin
        rdata_r[7:0] <= rxbuf_r;
      end
      if (is_reg(s_axi_araddr_i, `OFF_TXBUF)) begin
        rdata_r[7:0] <= txbuf_r;
      end
      if (is_reg(s_axi_araddr_i, `OFF_CTRL)) begin
        rdata_r[7:0] <= ctrl_r;
      end
      if (is_reg(s_axi_araddr_i, `OFF_IRQ_STAT)) begin
        rdata_r[7:0] <= irq_stat_r;
      end
      if (is_reg(s_axi_araddr_i, `OFF_IRQ_MASK)) begin
        rdata_r[7:0] <= irq_mask_r;
      end
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ctrl_r     <= `CTRL_RST;
      loop_r     <= 1'b0;
      irq_mask_r <= 8'h00;
    end else if (wr_en) begin
      if (is_reg(aw_addr_r, `OFF_CTRL)) begin
        ctrl_r <= w_data_r;
      end
      if (is_reg(aw_addr_r, `OFF_STATUS)) begin
        loop_r <= w_data_r[`ST_LOOP];
      end
      if (is_reg(aw_addr_r, `OFF_IRQ_MASK)) begin
        irq_mask_r <= w_data_r;
      end
    end
  end

  // ****************************************
  // transmit buffer
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!core_rst_b) begin
      txbuf_r   <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (wr_tx) begin
      // msb held reset for seven-bit characters
      txbuf_r   <= ctrl_r[`CTRL_SEVEN] ? {1'b0, w_data_r[6:0]} : w_data_r;
      tx_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  // ****************************************
  // receive buffer and flags
  // ****************************************
  // a new character arriving with a read wins: its flags stand
  always_ff @(posedge core_clk_i) begin
    if (!core_rst_b) begin
      rxbuf_r   <= 8'h00;
      rx_full_r <= 1'b0;
      fe_r      <= 1'b0;
      oe_r      <= 1'b0;
      pe_r      <= 1'b0;
      brk_r     <= 1'b0;
      ai_r      <= 1'b0;
    end else if (ifc.rx_valid) begin
      rxbuf_r   <= ifc.rx_data;
      rx_full_r <= 1'b1;
      fe_r      <= (fe_r && !rd_rx) || ifc.rx_fe;
      oe_r      <= (oe_r && !rd_rx) || (rx_full_r && !rd_rx);
      pe_r      <= (pe_r && !rd_rx) || ifc.rx_pe;
      brk_r     <= (brk_r && !rd_rx) || ifc.rx_brk;
      case (ifc.mode)
        uart_status_pkg::MP_ADDR: ai_r <= ifc.rx_addr;
        uart_status_pkg::MP_IDLE: ai_r <= ifc.rx_idle;
        default:                  ai_r <= 1'b0;
      endcase
    end else if (rd_rx) begin
      rx_full_r <= 1'b0;
      fe_r      <= 1'b0;
      oe_r      <= 1'b0;
      pe_r      <= 1'b0;
      brk_r     <= 1'b0;
      ai_r      <= 1'b0;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign rx_err = ifc.rx_fe || ifc.rx_brk || (ifc.rx_pe && ctrl_r[`CTRL_PEN]) ||
                  (rx_full_r && !rd_rx);

  always_comb begin
    irq_set = 8'h00;
    irq_set[`IRQ_RX]  = ifc.rx_valid;
    irq_set[`IRQ_TX]  = tx_load;
    irq_set[`IRQ_ERR] = ifc.rx_valid && rx_err;
    irq_w1c = 8'h00;
    if (wr_en && is_reg(aw_addr_r, `OFF_IRQ_STAT)) begin
      irq_w1c = w_data_r;
    end
    irq_w1c[`IRQ_RX] = irq_w1c[`IRQ_RX] || rd_rx;
    irq_w1c[`IRQ_TX] = irq_w1c[`IRQ_TX] || wr_tx;
  end

  // set beats clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!core_rst_b) begin
      irq_stat_r <= `IRQ_STAT_RST;
    end else begin
      irq_stat_r <= ((irq_stat_r & ~irq_w1c) | irq_set) & 8'h07;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);
endmodule : uart_status_buffers
`default_nettype wire

// file: tb/uart_far_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_consts.svh"
// ****************
// remote serial transceiver
// ****************
module uart_far_end (
  input  wire logic clk_i,
  input  wire logic line_from_dut_i,
  output logic      line_to_dut_o
);
  // idle line rests high, as a pulled-up line would
  initial line_to_dut_o = 1'h1;
  // frame bits go out lsb first, start bit in bit 0
  task automatic send(input logic [11:0] f, input int n, input int gap);
    repeat (gap) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_to_dut_o <= f[i];
      repeat (`BIT_CYCLES) @(posedge clk_i);
    end
    line_to_dut_o <= 1'h1;
  endtask : send
  // nine bits after the start bit, sampled mid-bit
  task automatic get(output logic [8:0] v);
    int k;
    v = 'x;
    for (k = 0; k < 20000 && line_from_dut_i !== 1'h0; k++) @(posedge clk_i);
    if (k == 20000) return;
    repeat (`BIT_CYCLES / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (`BIT_CYCLES) @(posedge clk_i);
      v[i] = line_from_dut_i;
    end
  endtask : get
endmodule : uart_far_end
`default_nettype wire

// file: tb/uart_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_consts.svh"
// ****************
// status and buffer checks
// ****************
module uart_status_asserts (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  input  wire logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic        s_axi_wvalid_i,
  input  wire logic        s_axi_wready_o,
  input  wire logic        s_axi_bvalid_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  input  wire logic        s_axi_arready_o,
  input  wire logic [31:0] s_axi_rdata_o,
  input  wire logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        serial_tx_line_o
);
  logic [7:0] aw_r, wd_r, ar_r, ctrl_r;
  logic       bv_r, loop_r;
  wire        rk = s_axi_rvalid_o && s_axi_rready_i;
  wire        st = rk && ar_r == `OFF_STATUS;
  always_ff @(posedge core_clk_i) begin
    if (s_axi_awvalid_i && s_axi_awready_o) aw_r <= s_axi_awaddr_i;
    if (s_axi_wvalid_i && s_axi_wready_o) wd_r <= s_axi_wdata_i[7:0];
    if (s_axi_arvalid_i && s_axi_arready_o) ar_r <= s_axi_araddr_i;
  end
  // shadow lags the real register a cycle; reads never come sooner
  always_ff @(posedge core_clk_i) begin
    bv_r <= s_axi_bvalid_o;
    if (!rst_b_i) begin
      ctrl_r <= `CTRL_RST;
      loop_r <= 1'h0;
    end else if (s_axi_bvalid_o && !bv_r) begin
      if (aw_r == `OFF_CTRL) ctrl_r <= wd_r;
      if (aw_r == `OFF_STATUS) loop_r <= wd_r[`ST_LOOP];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  loop_bit_a: assert property (st |-> s_axi_rdata_o[7] == loop_r)
    else $error("loopback bit differs from write");
  parity_off_a: assert property (st && !ctrl_r[`CTRL_PEN] |-> !s_axi_rdata_o[4])
    else $error("parity flag set with parity off");
  err_sum_a: assert property (st |-> s_axi_rdata_o[2] == |s_axi_rdata_o[6:3])
    else $error("summary flag wrong");
  busy_tx_a: assert property (st && $past(serial_tx_line_o) == 1'h0 |-> s_axi_rdata_o[0])
    else $error("busy low while sending");
  rx_seven_a: assert property (rk && ar_r == `OFF_RXBUF && ctrl_r[`CTRL_SEVEN]
    |-> !s_axi_rdata_o[7]) else $error("receive msb set in seven-bit mode");
  tx_seven_a: assert property (rk && ar_r == `OFF_TXBUF && ctrl_r[`CTRL_SEVEN]
    |-> !s_axi_rdata_o[7]) else $error("transmit msb set in seven-bit mode");
  tx_idle_a: assert property (ctrl_r[`CTRL_SWRST] |-> serial_tx_line_o)
    else $error("line active in software reset");
  brk_frame_a: assert property (st && s_axi_rdata_o[3] |-> s_axi_rdata_o[6])
    else $error("break without framing flag");
endmodule : uart_status_asserts
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_consts.svh"
// ****************
// register-level bench
// ****************
module testbench;
  logic        core_clk_i = 1'h0, rst_b_i = 1'h0, s_axi_bready_i = 1'h1, s_axi_rready_i = 1'h1;
  logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_arvalid_i = 1'h0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic        s_axi_rvalid_o, serial_rx_line_i, serial_tx_line_o, irq_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [8:0]  v;
  int          bad_count = 0, checks_done = 0;
  uart_status_buffers i_dut (.*);
  uart_far_end i_far (.clk_i(core_clk_i), .line_from_dut_i(serial_tx_line_o),
    .line_to_dut_o(serial_rx_line_i));
  always #12.5 core_clk_i = ~core_clk_i;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stall(input string nm);
    bad_count++;
    $display("ERROR %s expected answer seen none", nm);
    wrap_up();
  endtask : stall
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h00_0000, d};
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk_i);
      if (s_axi_awready_o === 1'h1) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o === 1'h1) s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o === 1'h1) break;
    end
    if (k == 50) stall("bvalid");
    chk("bresp", (a > 8'h14) ? 2'h2 : 2'h0, s_axi_bresp_o);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    int k;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk_i);
      if (s_axi_arready_o === 1'h1) s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o === 1'h1) break;
    end
    if (k == 50) stall("rvalid");
    chk("rresp", (a > 8'h14) ? 2'h2 : 2'h0, s_axi_rresp_o);
    chk($sformatf("rdata %h", a), {24'h00_0000, e}, s_axi_rdata_o & {24'h00_0000, m});
  endtask : rd
  task automatic wirq();
    int k;
    for (k = 0; k < 20000 && irq_o !== 1'h1; k++) @(posedge core_clk_i);
    if (k == 20000) stall("irq");
  endtask : wirq
  // one received frame: status, buffer, then clear all pending events
  task automatic rxc(input logic [11:0] f, input int n, input int gap, input logic [7:0] st,
                     input logic [7:0] d, input logic [7:0] dm);
    i_far.send(f, n, gap);
    wirq();
    rd(8'h00, st, 8'h7E);
    rd(8'h04, d, dm);
    wr(8'h10, 8'h07);
  endtask : rxc
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'h1;
    rd(8'h00, 8'h00, 8'hFF);
    rd(8'h0C, 8'h01, 8'hFF);
    rd(8'h10, 8'h02, 8'hFF);
    rd(8'h14, 8'h00, 8'hFF);
    rd(8'h18, 8'h00, 8'hFF);
    wr(8'h18, 8'h5A);
    chk("irq", 1'h0, irq_o);
    wr(8'h0C, 8'h00);
    wr(8'h14, 8'h02);
    chk("irq", 1'h1, irq_o);
    wr(8'h14, 8'h05);
    chk("irq", 1'h0, irq_o);
    $display("done: registers");
    wr(8'h08, 8'hA5);
    @(posedge core_clk_i);
    rd(8'h00, 8'h01, 8'h01);
    i_far.get(v);
    chk("tx frame", {1'h1, 8'hA5}, v);
    rd(8'h08, 8'hA5, 8'hFF);
    repeat (`BIT_CYCLES) @(posedge core_clk_i);
    rd(8'h00, 8'h00, 8'h01);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h80, 8'h80);
    wr(8'h08, 8'h3C);
    wirq();
    rd(8'h04, 8'h3C, 8'hFF);
    @(posedge core_clk_i);
    chk("irq", 1'h0, irq_o);
    repeat (`BIT_CYCLES) @(posedge core_clk_i);
    wr(8'h00, 8'h00);
    $display("done: transmit and loopback");
    wr(8'h0C, 8'h0E);
    wr(8'h08, 8'h80);
    i_far.get(v);
    chk("tx frame", 9'h100, v);
    rd(8'h08, 8'h00, 8'hFF);
    wr(8'h08, 8'h00);
    rd(8'h10, 8'h00, 8'h02);
    rxc({2'h3, 7'h00, 1'h0}, 10, 0, 8'h14, 8'h00, 8'hFF);
    rd(8'h00, 8'h00, 8'h7E);
    rd(8'h10, 8'h00, 8'h04);
    wr(8'h0C, 8'h08);
    rxc({1'h1, 7'h7F, 1'h0}, 9, 0, 8'h00, 8'h7F, 8'hFF);
    $display("done: seven-bit and parity");
    wr(8'h0C, 8'h00);
    i_far.send({1'h1, 8'h11, 1'h0}, 10, 0);
    rxc({1'h1, 8'h22, 1'h0}, 10, 0, 8'h24, 8'h00, 8'h00);
    rxc({1'h0, 8'h12, 1'h0}, 10, 0, 8'h44, 8'h00, 8'h00);
    rxc({1'h0, 8'h00, 1'h0}, 10, 0, 8'h4C, 8'h00, 8'h00);
    $display("done: receive errors");
    wr(8'h0C, 8'h20);
    rxc({2'h3, 8'h11, 1'h0}, 11, 0, 8'h02, 8'h11, 8'hFF);
    rxc({2'h2, 8'h22, 1'h0}, 11, 0, 8'h00, 8'h22, 8'hFF);
    wr(8'h0C, 8'h10);
    rxc({1'h1, 8'h33, 1'h0}, 10, 3600, 8'h02, 8'h33, 8'hFF);
    rxc({1'h1, 8'h44, 1'h0}, 10, 0, 8'h00, 8'h44, 8'hFF);
    $display("done: multiprocessor modes");
    wrap_up();
  end
endmodule : testbench
bind uart_status_buffers uart_status_asserts i_chk (.*);
`default_nettype wire
